/* File: core/gob_pkg.sv */
package gob_pkg;

  // -------------------------------------------------------------------------
  // register indexes; byte address on the bus is four times the index
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFF_PACK      = 8'h28;
  localparam logic [7:0] OFF_GAUGE     = 8'h29;
  localparam logic [7:0] OFF_MISC      = 8'h2a;
  localparam logic [7:0] OFF_CHECK_T   = 8'he4;
  localparam logic [7:0] OFF_SLP_THR   = 8'he5;
  localparam logic [7:0] OFF_SLP_TIME  = 8'he6;
  localparam logic [7:0] OFF_FAIL_LIM  = 8'he8;
  localparam logic [7:0] OFF_STATUS    = 8'hf0;
  localparam logic [7:0] OFF_INPUTS    = 8'hf4;

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0]  RST_PACK     = 8'h00;
  localparam logic [7:0]  RST_GAUGE    = 8'h00;
  localparam logic [7:0]  RST_MISC     = 8'h00;
  localparam logic [7:0]  RST_CHECK_T  = 8'h01;
  localparam logic [7:0]  RST_SLP_THR  = 8'h00;
  localparam logic [7:0]  RST_SLP_TIME = 8'h01;
  localparam logic [15:0] RST_FAIL_LIM = 16'hffff;

  // reserved bits held at zero
  localparam logic [7:0] GAUGE_WMASK  = 8'h7f;
  localparam logic [7:0] MISC_WMASK   = 8'hbf;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ          = 250;
  localparam int SLEEP_IDLE_MS    = 2000;
  localparam int SLEEP_IDLE_CYC   = SLEEP_IDLE_MS * 1000 * CLK_MHZ;
  localparam int FET_DELAY_MS     = 1000;
  localparam int FET_DELAY_CYC    = FET_DELAY_MS * 1000 * CLK_MHZ;
  localparam int SEC_CYC          = 1000 * 1000 * CLK_MHZ;

  // -------------------------------------------------------------------------
  // decoded controls
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {GOB_LED3, GOB_LED4, GOB_LED5} gob_led_count_t;

  typedef struct packed {
    logic       display_relative;
    logic [2:0] led_count;
    logic       host_pec;
    logic       charger_pec;
    logic       broadcast_en;
    logic [2:0] cell_count;
    logic       capacity_sync_on_term;
    logic       independent_charger;
    logic       eod_compensation_enable;
    logic       eod_on_pack_voltage;
    logic       ov_on_highest_cell;
    logic       continuous_midrange_corr;
    logic       internal_temp;
    logic       precharge_fet_enable;
  } gob_ctrl_t;

  typedef struct packed {
    logic        haddr_sel;
    logic [7:0]  addr;
    logic        write;
  } gob_req_t;

endpackage

/* File: core/gob_decode.sv */
`timescale 1ns/1ps
// What this block does
// - display bit picks relative or absolute charge
// - led field: 01 three, 10 four, else five
// - host pec bit adds pec to alarms
// - charger pec bit adds pec to broadcasts
// - inhibit bit blocks broadcasts, mode cannot override
// - cell field: 11 four cells, 10 three
// - sync bit loads capacity at charge termination
// - charger type bit picks learning optimisation
// - compensation bit computes or fixes eod thresholds
// - eod basis: lowest cell or pack voltage
// - overvoltage basis: pack or highest cell times count
// - continuous midrange correction enable
// - one midrange correction after each reset
// - integrity check period, flag after fail limit
// - sleep current threshold in half milliamps
// - sleep wake period in half seconds
// - temp source bit picks internal sensor
// - integrity fail drives safe output if enabled
// - sleep after bus low two seconds unless disabled
// - overtemp kills charge fet, discharge if enabled
// - leds while charging only if enabled
// - precharge fet control only when enabled
// - optional one second fet action delay
module gob_decode
  import gob_pkg::*;
#(
  parameter int SLEEP_IDLE_CYCLES = gob_pkg::SLEEP_IDLE_CYC,
  parameter int FET_DELAY_CYCLES  = gob_pkg::FET_DELAY_CYC,
  parameter int SECOND_CYCLES     = gob_pkg::SEC_CYC
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // smbus line levels
  input  wire logic              smb_clk_in,
  input  wire logic              smb_data_in,
  // gauge events and state
  input  wire logic              charge_term_event,
  input  wire logic              integrity_fail_event,
  input  wire logic              overtemp,
  input  wire logic              discharging,
  input  wire logic              fet_chg_req,
  input  wire logic              fet_dsg_req,
  input  wire logic              precharge_req,
  // decoded controls
  output gob_pkg::gob_ctrl_t     ctrl,
  output logic                   load_capacity,
  output logic                   one_time_corr,
  output logic                   integrity_check_tick,
  output logic                   integrity_fail_flag,
  output logic                   safe_out,
  output logic                   sleep_mode,
  output logic [7:0]             sleep_current_units,
  output logic [8:0]             wake_period_halfsec,
  output logic                   led_enable,
  output logic                   chg_fet_on,
  output logic                   dsg_fet_on,
  output logic                   precharge_fet_on
);
  import gob_pkg::*;

  if (SLEEP_IDLE_CYCLES < 1 || FET_DELAY_CYCLES < 1 || SECOND_CYCLES < 1) begin : g_bad_cfg
    $error("gob_decode: cycle counts must be positive");
  end

  // -------------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------------
  logic [7:0]  pack_feature_bits;
  logic [7:0]  gauge_feature_bits;
  logic [7:0]  misc_feature_bits;
  logic [7:0]  check_period;
  logic [7:0]  sleep_thresh;
  logic [7:0]  sleep_time;
  logic [15:0] fail_limit;
  logic        wr_pend;
  logic [7:0]  wr_addr;

  // zero-wait slave; only word accesses matter, all answers okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[9:2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pack_feature_bits  <= RST_PACK;
      gauge_feature_bits <= RST_GAUGE;
      misc_feature_bits  <= RST_MISC;
      check_period       <= RST_CHECK_T;
      sleep_thresh       <= RST_SLP_THR;
      sleep_time         <= RST_SLP_TIME;
      fail_limit         <= RST_FAIL_LIM;
    end else if (wr_pend) begin
      case (wr_addr)
        OFF_PACK:     pack_feature_bits  <= hwdata[7:0];
        OFF_GAUGE:    gauge_feature_bits <= hwdata[7:0] & GAUGE_WMASK;
        OFF_MISC:     misc_feature_bits  <= hwdata[7:0] & MISC_WMASK;
        OFF_CHECK_T:  check_period       <= hwdata[7:0];
        OFF_SLP_THR:  sleep_thresh       <= hwdata[7:0];
        OFF_SLP_TIME: sleep_time         <= hwdata[7:0];
        OFF_FAIL_LIM: fail_limit         <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  logic [7:0]  rd_addr;
  logic [31:0] rd_mux;
  logic        smb_clk_s;
  logic        smb_data_s;

  assign rd_addr = haddr[9:2];

  always_comb begin
    case (rd_addr)
      OFF_PACK:     rd_mux = {24'h000000, pack_feature_bits};
      OFF_GAUGE:    rd_mux = {24'h000000, gauge_feature_bits};
      OFF_MISC:     rd_mux = {24'h000000, misc_feature_bits};
      OFF_CHECK_T:  rd_mux = {24'h000000, check_period};
      OFF_SLP_THR:  rd_mux = {24'h000000, sleep_thresh};
      OFF_SLP_TIME: rd_mux = {24'h000000, sleep_time};
      OFF_FAIL_LIM: rd_mux = {16'h0000, fail_limit};
      OFF_STATUS:   rd_mux = {29'h00000000, one_time_corr, sleep_mode, integrity_fail_flag};
      OFF_INPUTS:   rd_mux = {30'h00000000, smb_data_s, smb_clk_s};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // read data flopped at the address phase so it stands through the data phase
  // limitation: a read issued during a write data phase to the same register sees old data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // -------------------------------------------------------------------------
  // option decode
  // -------------------------------------------------------------------------
  always_comb begin
    ctrl.display_relative = pack_feature_bits[7];
    case (pack_feature_bits[6:5])
      2'h1:    ctrl.led_count = 3'h3;
      2'h2:    ctrl.led_count = 3'h4;
      default: ctrl.led_count = 3'h5;
    endcase
    ctrl.broadcast_en = !pack_feature_bits[2];
    ctrl.host_pec    = pack_feature_bits[4] && ctrl.broadcast_en;
    ctrl.charger_pec = pack_feature_bits[3] && ctrl.broadcast_en;
    case (pack_feature_bits[1:0])
      2'h3:    ctrl.cell_count = 3'h4;
      default: ctrl.cell_count = 3'h3;
    endcase
    ctrl.capacity_sync_on_term    = gauge_feature_bits[6];
    ctrl.independent_charger      = gauge_feature_bits[5];
    ctrl.eod_compensation_enable  = gauge_feature_bits[4];
    ctrl.eod_on_pack_voltage      = gauge_feature_bits[3];
    ctrl.ov_on_highest_cell       = gauge_feature_bits[2];
    ctrl.continuous_midrange_corr = gauge_feature_bits[1];
    ctrl.internal_temp            = misc_feature_bits[7];
    ctrl.precharge_fet_enable     = misc_feature_bits[1];
  end

  assign load_capacity = charge_term_event && ctrl.capacity_sync_on_term;

  assign sleep_current_units = sleep_thresh;
  assign wake_period_halfsec = {1'b0, sleep_time};

  logic corr_done;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_done     <= 1'b0;
      one_time_corr <= 1'b0;
    end else begin
      // armed by each reset; options are written after reset, so wait for the bit
      corr_done     <= corr_done || gauge_feature_bits[0];
      one_time_corr <= !corr_done && gauge_feature_bits[0];
    end
  end

  // -------------------------------------------------------------------------
  // integrity check
  // -------------------------------------------------------------------------
  logic [31:0] sec_cnt;
  logic [7:0]  check_cnt;
  logic [15:0] fail_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt              <= 32'h00000000;
      check_cnt            <= 8'h00;
      integrity_check_tick <= 1'b0;
    end else begin
      integrity_check_tick <= 1'b0;
      if (sec_cnt == 32'(SECOND_CYCLES - 1)) begin
        sec_cnt <= 32'h00000000;
        if (check_cnt + 8'h01 >= check_period) begin
          check_cnt            <= 8'h00;
          integrity_check_tick <= 1'b1;
        end else begin
          check_cnt <= check_cnt + 8'h01;
        end
      end else begin
        sec_cnt <= sec_cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_cnt            <= 16'h0000;
      integrity_fail_flag <= 1'b0;
    end else if (integrity_fail_event) begin
      if (fail_cnt != 16'hffff) begin
        fail_cnt <= fail_cnt + 16'h0001;
      end
      if (fail_cnt + 16'h0001 >= fail_limit) begin
        integrity_fail_flag <= 1'b1;
      end
    end
  end

  assign safe_out = integrity_fail_flag && misc_feature_bits[5];

  // -------------------------------------------------------------------------
  // sleep on bus idle
  // -------------------------------------------------------------------------
  logic [1:0]  clk_sync;
  logic [1:0]  dat_sync;
  logic [31:0] idle_cnt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_sync <= 2'h3;
      dat_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[0], smb_clk_in};
      dat_sync <= {dat_sync[0], smb_data_in};
    end
  end
  assign smb_clk_s  = clk_sync[1];
  assign smb_data_s = dat_sync[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt   <= 32'h00000000;
      sleep_mode <= 1'b0;
    end else if (smb_clk_s || smb_data_s || misc_feature_bits[4]) begin
      idle_cnt   <= 32'h00000000;
      sleep_mode <= 1'b0;
    end else if (idle_cnt >= 32'(SLEEP_IDLE_CYCLES - 1)) begin
      sleep_mode <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 32'h00000001;
    end
  end

  assign led_enable = discharging || misc_feature_bits[2];

  // -------------------------------------------------------------------------
  // fet control
  // -------------------------------------------------------------------------
  logic        want_chg;
  logic        want_dsg;
  logic [31:0] dly_cnt;

  assign want_chg = fet_chg_req && !overtemp;
  assign want_dsg = fet_dsg_req && !(overtemp && misc_feature_bits[3]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_cnt    <= 32'h00000000;
      chg_fet_on <= 1'b0;
      dsg_fet_on <= 1'b0;
    end else if (want_chg == chg_fet_on && want_dsg == dsg_fet_on) begin
      dly_cnt <= 32'h00000000;
    end else if (!misc_feature_bits[0] || dly_cnt >= 32'(FET_DELAY_CYCLES - 1)) begin
      dly_cnt    <= 32'h00000000;
      chg_fet_on <= want_chg;
      dsg_fet_on <= want_dsg;
    end else begin
      dly_cnt <= dly_cnt + 32'h00000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      precharge_fet_on <= 1'b0;
    end else begin
      precharge_fet_on <= precharge_req && ctrl.precharge_fet_enable;
    end
  end

endmodule // gob_decode

/* File: dv/gob_smb_partner.sv */
`timescale 1ns/1ps
module gob_smb_partner (
  // test controls
  input  wire logic hold_low,
  input  wire logic frame,
  // bus lines, pulled up when released
  output logic      smb_clk,
  output logic      smb_data
);
  // -----------------------------------------------------------------------
  // line behaviour
  // -----------------------------------------------------------------------
  initial begin
    smb_clk = 1'b1;
    smb_data = 1'b1;
    forever begin
      #24;
      if (hold_low) begin
        smb_clk = 1'b0;
        smb_data = 1'b0;
      end else if (frame) begin
        smb_clk = ~smb_clk;
        smb_data = smb_clk ? smb_data : ~smb_data;
      end else begin
        // released lines float back up, clock stands still between frames
        smb_clk = 1'b1;
        smb_data = 1'b1;
      end
    end
  end
endmodule // gob_smb_partner

/* File: dv/gob_checker.sv */
`timescale 1ns/1ps
module gob_checker
  import gob_pkg::*;
#(
  parameter int SLEEP_IDLE_CYCLES = 50,
  parameter int FET_DELAY_CYCLES  = 20
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              smb_clk_in,
  input wire logic              smb_data_in,
  input wire logic              charge_term_event,
  input wire logic              integrity_fail_event,
  input wire logic              overtemp,
  input wire logic              discharging,
  input wire gob_pkg::gob_ctrl_t ctrl,
  input wire logic              load_capacity,
  input wire logic              one_time_corr,
  input wire logic              integrity_check_tick,
  input wire logic              integrity_fail_flag,
  input wire logic              safe_out,
  input wire logic              sleep_mode,
  input wire logic              led_enable,
  input wire logic              chg_fet_on
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] low_cnt;
  logic [15:0] ot_cnt;
  // run length of both lines low, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 16'h0;
    else if (smb_clk_in | smb_data_in) low_cnt <= 16'h0;
    else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ot_cnt <= 16'h0;
    else if (!overtemp) ot_cnt <= 16'h0;
    else if (ot_cnt != 16'hffff) ot_cnt <= ot_cnt + 16'h1;
  end
  // -----------------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------------
  sequence s_tick_quiet; !integrity_check_tick [*8]; endsequence
  sequence s_lines_up; (smb_clk_in | smb_data_in) [*4]; endsequence
  property p_load_sync; load_capacity == (charge_term_event & ctrl.capacity_sync_on_term);
  endproperty
  property p_safe_cause; safe_out |-> integrity_fail_flag; endproperty
  property p_fail_sticky; integrity_fail_flag |=> integrity_fail_flag; endproperty
  property p_fail_cause; $rose(integrity_fail_flag) |-> $past(integrity_fail_event); endproperty
  property p_tick_gap; integrity_check_tick |=> s_tick_quiet; endproperty
  property p_led_dsg; discharging |-> led_enable; endproperty
  property p_host_pec; ctrl.host_pec |-> ctrl.broadcast_en; endproperty
  property p_sleep_wake; s_lines_up |-> !sleep_mode; endproperty
  property p_sleep_late; $rose(sleep_mode) |-> low_cnt >= SLEEP_IDLE_CYCLES; endproperty
  property p_ot_chg; ot_cnt >= FET_DELAY_CYCLES + 4 |-> !chg_fet_on; endproperty
  property p_one_time; $rose(one_time_corr) |=> !one_time_corr; endproperty
  a_load_sync: assert property (p_load_sync) else $error("capacity load mismatch");
  a_safe_cause: assert property (p_safe_cause) else $error("safe without failure");
  a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag dropped");
  a_fail_cause: assert property (p_fail_cause) else $error("fail flag without event");
  a_tick_gap: assert property (p_tick_gap) else $error("check ticks too close");
  a_led_dsg: assert property (p_led_dsg) else $error("leds off in discharge");
  a_host_pec: assert property (p_host_pec) else $error("pec while inhibited");
  a_sleep_wake: assert property (p_sleep_wake) else $error("asleep with bus high");
  a_sleep_late: assert property (p_sleep_late) else $error("sleep too early");
  a_ot_chg: assert property (p_ot_chg) else $error("charge fet on in overtemp");
  a_one_time: assert property (p_one_time) else $error("one time pulse too long");
endmodule // gob_checker

bind gob_decode gob_checker #(
  .SLEEP_IDLE_CYCLES(SLEEP_IDLE_CYCLES),
  .FET_DELAY_CYCLES (FET_DELAY_CYCLES)
) gob_checker_i (.hclk, .hresetn, .smb_clk_in, .smb_data_in, .charge_term_event,
  .integrity_fail_event, .overtemp, .discharging, .ctrl, .load_capacity, .one_time_corr,
  .integrity_check_tick, .integrity_fail_flag, .safe_out, .sleep_mode, .led_enable,
  .chg_fet_on);

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import gob_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, smb_clk, smb_data;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic charge_term_event, integrity_fail_event, overtemp, discharging, hold_low, frame;
  logic fet_chg_req, fet_dsg_req, precharge_req, load_capacity, one_time_corr, safe_out;
  logic integrity_check_tick, integrity_fail_flag, sleep_mode, led_enable;
  logic chg_fet_on, dsg_fet_on, precharge_fet_on;
  logic [7:0] sleep_current_units;
  logic [8:0] wake_period_halfsec;
  gob_ctrl_t ctrl;
  int mismatches = 0;
  int samples_checked = 0;
  int otc_seen = 0;
  gob_decode #(.SLEEP_IDLE_CYCLES(50), .FET_DELAY_CYCLES(20), .SECOND_CYCLES(10)) gob_decode_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .smb_clk_in(smb_clk), .smb_data_in(smb_data), .charge_term_event,
    .integrity_fail_event, .overtemp, .discharging, .fet_chg_req, .fet_dsg_req, .precharge_req,
    .ctrl, .load_capacity, .one_time_corr, .integrity_check_tick, .integrity_fail_flag,
    .safe_out, .sleep_mode, .sleep_current_units, .wake_period_halfsec, .led_enable,
    .chg_fet_on, .dsg_fet_on, .precharge_fet_on);
  gob_smb_partner gob_smb_partner_i (.hold_low, .frame, .smb_clk, .smb_data);
  // counts one-time correction pulses
  always @(posedge hclk) if (one_time_corr === 1'b1) otc_seen++;
  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic fail_pulse;
    @(posedge hclk);
    integrity_fail_event <= 1'b1;
    @(posedge hclk);
    integrity_fail_event <= 1'b0;
  endtask
  // -----------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------
  task automatic t_reset_values;
    rd_chk(OFF_PACK, 32'h0);
    rd_chk(OFF_CHECK_T, {24'h0, RST_CHECK_T});
    rd_chk(OFF_FAIL_LIM, {16'h0, RST_FAIL_LIM});
    rd_chk(OFF_SLP_TIME, {24'h0, RST_SLP_TIME});
    rd_chk(8'h80, 32'h0);
  endtask
  task automatic t_pack;
    logic [7:0] tbl [6] = '{8'h20, 8'h40, 8'h60, 8'h9b, 8'h06, 8'h14};
    foreach (tbl[i]) begin
      wr(OFF_PACK, {24'h0, tbl[i]});
      rd_chk(OFF_PACK, {24'h0, tbl[i]});
      @(negedge hclk);
      chk(ctrl.display_relative, tbl[i][7]);
      chk(ctrl.led_count, tbl[i][6:5] == 2'b01 ? 32'h3 : tbl[i][6:5] == 2'b10 ? 32'h4 : 32'h5);
      chk(ctrl.host_pec, tbl[i][4] & !tbl[i][2]);
      chk(ctrl.charger_pec, tbl[i][3]);
      chk(ctrl.broadcast_en, !tbl[i][2]);
      if (tbl[i][1]) chk(ctrl.cell_count, tbl[i][0] ? 32'h4 : 32'h3);
    end
  endtask
  task automatic t_gauge;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'h1 << i;
      wr(OFF_GAUGE, {24'h0, v});
      rd_chk(OFF_GAUGE, {24'h0, v & 8'h7f});
      @(negedge hclk);
      chk({ctrl.capacity_sync_on_term, ctrl.independent_charger, ctrl.eod_compensation_enable,
           ctrl.eod_on_pack_voltage, ctrl.ov_on_highest_cell, ctrl.continuous_midrange_corr},
          v[6:1]);
    end
    chk(otc_seen, 32'd1);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_GAUGE, s ? 32'h40 : 32'h0);
      @(posedge hclk);
      charge_term_event <= 1'b1;
      @(negedge hclk);
      chk(load_capacity, s == 1);
      @(posedge hclk);
      charge_term_event <= 1'b0;
    end
  endtask
  task automatic t_misc;
    wr(OFF_MISC, 32'hff);
    rd_chk(OFF_MISC, 32'hbf);
    for (int s = 0; s < 2; s++) begin
      wr(OFF_MISC, s ? 32'h04 : 32'h80);
      settle(0);
      chk(ctrl.internal_temp, s == 0);
      chk(led_enable, s == 1);
    end
  endtask
  task automatic t_fail;
    wr(OFF_FAIL_LIM, 32'h3);
    wr(OFF_MISC, 32'h20);
    for (int i = 1; i <= 3; i++) begin
      fail_pulse();
      @(negedge hclk);
      chk(integrity_fail_flag, i == 3);
      chk(safe_out, i == 3);
    end
    rd_chk(OFF_STATUS, 32'h1);
    wr(OFF_MISC, 32'h0);
    settle(0);
    chk(safe_out, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic t_sleep;
    for (int s = 0; s < 2; s++) begin
      wr(OFF_MISC, s ? 32'h10 : 32'h0);
      hold_low <= 1'b1;
      settle(70);
      chk(sleep_mode, s == 0);
      rd_chk(OFF_INPUTS, 32'h0);
      @(posedge hclk);
      hold_low <= 1'b0;
      settle(12);
      chk(sleep_mode, 1'b0);
    end
    wr(OFF_MISC, 32'h0);
    frame <= 1'b1;
    settle(80);
    chk(sleep_mode, 1'b0);
    frame <= 1'b0;
  endtask
  task automatic t_fet;
    fet_chg_req <= 1'b1;
    fet_dsg_req <= 1'b1;
    overtemp <= 1'b1;
    settle(30);
    chk({chg_fet_on, dsg_fet_on}, 2'b01);
    wr(OFF_MISC, 32'h08);
    settle(3);
    chk({chg_fet_on, dsg_fet_on}, 2'b00);
    overtemp <= 1'b0;
    wr(OFF_MISC, 32'h01);
    settle(30);
    fet_chg_req <= 1'b0;
    settle(5);
    chk(chg_fet_on, 1'b1);
    settle(25);
    chk(chg_fet_on, 1'b0);
    precharge_req <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(OFF_MISC, s ? 32'h02 : 32'h0);
      settle(3);
      chk(precharge_fet_on, s == 1);
    end
  endtask
  task automatic t_timing;
    int n;
    wr(OFF_SLP_THR, 32'h14);
    wr(OFF_SLP_TIME, 32'hff);
    wr(OFF_CHECK_T, 32'h2);
    settle(0);
    chk(sleep_current_units, 32'h14);
    chk(wake_period_halfsec, 32'hff);
    do @(posedge hclk); while (integrity_check_tick !== 1'b1);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (integrity_check_tick !== 1'b1);
    chk(n, 32'd20);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, charge_term_event, integrity_fail_event, overtemp} = 6'h0;
    {discharging, fet_chg_req, fet_dsg_req, precharge_req, hold_low, frame} = 6'h0;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset_values();
    t_pack();
    t_gauge();
    t_misc();
    t_fail();
    t_sleep();
    t_fet();
    t_timing();
    wr(OFF_GAUGE, 32'h1);
    wr(OFF_GAUGE, 32'h1);
    settle(2);
    chk(otc_seen, 32'd2);
    discharging <= 1'b1;
    settle(2);
    chk(led_enable, 1'b1);
    final_report();
  end
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule // tb_top
